// File: hw/asc_serial0.sv
`timescale 1ns/1ps
`include "asc_consts.svh"
// What this block does
// - frame is one start bit then 7, 8 or 9 data bits per mode field
// - parity bit may be odd, even or absent
// - one or two stop bits close each frame
// - internal rate is f1, f8 or f32 over sixteen times divider plus one
// - external rate is transfer clock pin over sixteen times divider plus one
// - transmit starts only with transmit enable and buffer holding data
// - receive starts only with receive enable and a detected start bit
// - transmit request at buffer-to-shifter move or at shift completion, per select
// - receive request when character moves into receive buffer
// - overrun when buffer unread at bit before last stop of next character
// - framing error when configured stop bits are not found
// - parity error when ones count mismatches odd or even setting
// - summary flag set by any overrun, framing or parity error
// - framing and parity flags update at the buffer transfer moment
// - character sits in low buffer bits; higher received bits undefined
// - output idles high, or released when open drain is chosen
// - reading receive buffer upper byte clears parity, framing, receive complete
module asc_serial0
	import asc_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial pins
	input  wire logic        serial_in_pin,
	input  wire logic        transfer_clock_pin,
	output logic             serial_out_pin,
	output logic             serial_out_oe_n,
	// request pulses
	output logic             transmit_request,
	output logic             receive_request
);
	// ==========================================================
	// registers
	logic [7:0]    serial0_mode_reg;
	logic [7:0]    serial0_baud_divider;
	logic [7:0]    serial0_control_a;
	logic [7:0]    serial0_control_b;
	logic [8:0]    tx_buf;
	logic [8:0]    rx_data;
	logic          overrun_error_flag;
	logic          framing_error_flag;
	logic          parity_error_flag;
	logic          transmit_buffer_empty_flag;
	logic          receive_complete_flag;
	logic          shift_register_empty_flag;

	logic [2:0] serial_mode_field;
	logic       uart_on;
	logic [3:0] char_len;
	logic [3:0] frame_len;
	logic       parity_enable;
	logic       parity_type_sel;
	logic       stop_length_sel;
	logic       msb_first;

	assign serial_mode_field = serial0_mode_reg[2:0];
	assign parity_enable     = serial0_mode_reg[`ASC_MODE_PARITY_ENABLE_BIT];
	assign parity_type_sel   = serial0_mode_reg[`ASC_MODE_PRY_BIT];
	assign stop_length_sel   = serial0_mode_reg[`ASC_MODE_STOP_LENGTH_SEL_BIT];
	assign uart_on = (serial_mode_field == `ASC_SMD_ASYNC7) || (serial_mode_field == `ASC_SMD_ASYNC8)
		|| (serial_mode_field == `ASC_SMD_ASYNC9);
	// character width from the mode code; other codes leave the channel idle
	assign char_len  = (serial_mode_field == `ASC_SMD_ASYNC9) ? 4'h9 :
		(serial_mode_field == `ASC_SMD_ASYNC8) ? 4'h8 : 4'h7;
	// bits after the start bit: data, parity, stops
	assign frame_len = char_len + {3'h0, parity_enable} + {3'h0, stop_length_sel} + 4'h1;
	// bit order only honoured for 8-bit characters
	assign msb_first = serial0_control_a[`ASC_CA_ORDER_BIT] && (serial_mode_field == `ASC_SMD_ASYNC8);

	// ==========================================================
	// apb decode
	logic       setup_phase;
	logic       access_done;
	logic [9:0] word_idx;
	logic       idx_known;
	logic       wr_lo_tx;
	logic       rd_rx;

	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready;
	assign word_idx    = paddr[11:2];
	assign idx_known   = (word_idx == {2'h0, `ASC_IDX_MODE}) || (word_idx == {2'h0, `ASC_IDX_BAUD})
		|| (word_idx == {2'h0, `ASC_IDX_TX_BUF}) || (word_idx == {2'h0, `ASC_IDX_CTRL_A})
		|| (word_idx == {2'h0, `ASC_IDX_CTRL_B}) || (word_idx == {2'h0, `ASC_IDX_RX_BUF});
	// the low byte write is what hands the character over
	assign wr_lo_tx = access_done && pwrite && pstrb[0] && (word_idx == {2'h0, `ASC_IDX_TX_BUF});
	// apb reads are whole words, so every read covers the upper byte
	assign rd_rx    = access_done && !pwrite && (word_idx == {2'h0, `ASC_IDX_RX_BUF});

	// one wait-free answer: setup registers the reply, access completes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase && !idx_known;
			prdata  <= 32'h0000_0000;
			if (setup_phase && !pwrite) begin
				unique case (word_idx)
					{2'h0, `ASC_IDX_MODE}:   prdata <= {24'h0, serial0_mode_reg};
					{2'h0, `ASC_IDX_CTRL_A}: prdata <= {24'h0, serial0_control_a[7:4],
						shift_register_empty_flag, serial0_control_a[2:0]};
					{2'h0, `ASC_IDX_CTRL_B}: prdata <= {24'h0, serial0_control_b[7:4], receive_complete_flag,
						serial0_control_b[2], transmit_buffer_empty_flag, serial0_control_b[0]};
					{2'h0, `ASC_IDX_RX_BUF}: prdata <= {16'h0,
						overrun_error_flag | framing_error_flag | parity_error_flag,
						parity_error_flag, framing_error_flag, overrun_error_flag, 3'h0, rx_data};
					default:                 prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// software-written configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial0_mode_reg     <= `ASC_RST_MODE;
			serial0_baud_divider <= `ASC_RST_BAUD;
			serial0_control_a    <= `ASC_RST_CTRL_A;
			serial0_control_b    <= `ASC_RST_CTRL_B;
			tx_buf               <= 9'h000;
		end else if (access_done && pwrite && !pslverr) begin
			if (word_idx == {2'h0, `ASC_IDX_MODE} && pstrb[0])
				serial0_mode_reg <= pwdata[7:0];
			if (word_idx == {2'h0, `ASC_IDX_BAUD} && pstrb[0])
				serial0_baud_divider <= pwdata[7:0];
			if (word_idx == {2'h0, `ASC_IDX_CTRL_A} && pstrb[0])
				serial0_control_a <= pwdata[7:0];
			if (word_idx == {2'h0, `ASC_IDX_CTRL_B} && pstrb[0])
				serial0_control_b <= pwdata[7:0];
			if (word_idx == {2'h0, `ASC_IDX_TX_BUF}) begin
				if (pstrb[1])
					tx_buf[8] <= pwdata[8];
				if (pstrb[0])
					tx_buf[7:0] <= pwdata[7:0];
			end
		end
	end

	// ==========================================================
	// count source and baud ticks
	logic [4:0] pre_cnt;
	logic       clk_s1;
	logic       clk_s2;
	logic       clk_s3;
	logic       src_tick;
	logic [7:0] brg_cnt;
	logic       tick16;

	// external clock passes two flops; edge taken between second and third
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_s1  <= 1'b0;
			clk_s2  <= 1'b0;
			clk_s3  <= 1'b0;
			pre_cnt <= 5'h00;
		end else begin
			clk_s1  <= transfer_clock_pin;
			clk_s2  <= clk_s1;
			clk_s3  <= clk_s2;
			pre_cnt <= pre_cnt + 5'h01;
		end
	end

	always_comb begin
		if (serial0_mode_reg[`ASC_MODE_EXT_BIT])
			src_tick = clk_s2 && !clk_s3;
		else begin
			unique case (serial0_control_a[1:0])
				2'h1:    src_tick = ({2'h0, pre_cnt[2:0]} == `ASC_PRE_F8);
				2'h2:    src_tick = (pre_cnt == `ASC_PRE_F32);
				default: src_tick = 1'b1;
			endcase
		end
	end

	// divide the count source by n+1; each terminal count is one of sixteen ticks per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brg_cnt <= 8'h00;
			tick16  <= 1'b0;
		end else begin
			tick16 <= 1'b0;
			if (!uart_on)
				brg_cnt <= serial0_baud_divider;
			else if (src_tick) begin
				if (brg_cnt == 8'h00) begin
					brg_cnt <= serial0_baud_divider;
					tick16  <= 1'b1;
				end else
					brg_cnt <= brg_cnt - 8'h01;
			end
		end
	end

	// ==========================================================
	// transmitter
	asc_tx_state_e tx_state;
	logic [11:0]   tx_shift;
	logic [11:0]   next_tx_frame;
	logic [3:0]    tx_left;
	logic [3:0]    tx_tick;
	logic          tx_load;
	logic          tx_line;

	// frame after the start bit, lsb first on the wire; unused tail stays high
	always_comb begin
		logic [8:0] d;
		d = tx_buf;
		next_tx_frame = 12'hFFF;
		if (msb_first) begin
			for (int i = 0; i < 8; i++)
				d[i] = tx_buf[7 - i];
		end
		for (int i = 0; i < 9; i++) begin
			if (i < int'(char_len))
				next_tx_frame[i] = d[i];
		end
		if (parity_enable)
			next_tx_frame[char_len] = (^(d & ((9'h001 << char_len) - 9'h001))) ^ !parity_type_sel;
	end

	// loading waits a cycle if software is writing the low byte, so no character is torn
	assign tx_load = uart_on && serial0_control_b[`ASC_CB_TE_BIT] && !transmit_buffer_empty_flag
		&& (tx_state == TX_IDLE) && !wr_lo_tx;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state                  <= TX_IDLE;
			tx_shift                  <= 12'hFFF;
			tx_left                   <= 4'h0;
			tx_tick                   <= 4'h0;
			tx_line                   <= 1'b1;
			shift_register_empty_flag <= 1'b1;
		end else if (!uart_on) begin
			tx_state                  <= TX_IDLE;
			tx_line                   <= 1'b1;
			shift_register_empty_flag <= 1'b1;
		end else begin
			unique case (tx_state)
				TX_IDLE: if (tx_load) begin
					tx_state                  <= TX_SHIFT;
					tx_shift                  <= next_tx_frame;
					tx_left                   <= frame_len;
					tx_tick                   <= 4'h0;
					tx_line                   <= 1'b0;
					shift_register_empty_flag <= 1'b0;
				end
				TX_SHIFT: if (tick16) begin
					tx_tick <= tx_tick + 4'h1;
					if (tx_tick == `ASC_TICKS_PER_BIT) begin
						if (tx_left == 4'h0) begin
							tx_state                  <= TX_IDLE;
							shift_register_empty_flag <= 1'b1;
						end else begin
							tx_line  <= tx_shift[0];
							tx_shift <= {1'b1, tx_shift[11:1]};
							tx_left  <= tx_left - 4'h1;
						end
					end
				end
			endcase
		end
	end

	logic tx_done;
	assign tx_done = (tx_state == TX_SHIFT) && tick16 && (tx_tick == `ASC_TICKS_PER_BIT) && (tx_left == 4'h0);

	// buffer flag: software write fills it, the move to the shifter empties it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			transmit_buffer_empty_flag <= 1'b1;
		else if (tx_load)
			transmit_buffer_empty_flag <= 1'b1;
		else if (wr_lo_tx)
			transmit_buffer_empty_flag <= 1'b0;
	end

	// pin drive; open drain releases instead of driving high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_out_pin   <= 1'b1;
			serial_out_oe_n  <= 1'b0;
			transmit_request <= 1'b0;
		end else begin
			serial_out_pin   <= tx_line;
			serial_out_oe_n  <= serial0_control_a[`ASC_CA_NCH_BIT] && tx_line;
			transmit_request <= serial0_control_b[`ASC_CB_IRS_BIT] ? tx_done : tx_load;
		end
	end

	// ==========================================================
	// receiver
	asc_rx_state_e rx_state;
	logic          rx_s1;
	logic          rx_s2;
	logic [11:0]   rx_shift;
	logic [11:0]   rx_vec;
	logic [3:0]    rx_idx;
	logic [3:0]    rx_tick;
	logic          rx_sample;
	logic          rx_last;
	logic          rx_prelast;
	logic [8:0]    next_rx_data;
	logic          next_fer;
	logic          next_per;

	assign rx_sample  = (rx_state == RX_BITS) && tick16 && (rx_tick == `ASC_TICKS_PER_BIT);
	assign rx_last    = rx_sample && (rx_idx == frame_len - 4'h1);
	assign rx_prelast = rx_sample && (rx_idx == frame_len - 4'h2);

	// decode the frame including the bit sampled this cycle
	always_comb begin
		logic [8:0] d;
		d = 9'h000;
		rx_vec = rx_shift;
		rx_vec[rx_idx] = rx_s2;
		d = rx_vec[8:0];
		next_rx_data = d;
		if (msb_first) begin
			for (int i = 0; i < 8; i++)
				next_rx_data[i] = d[7 - i];
		end
		d = d & ((9'h001 << char_len) - 9'h001);
		next_per = parity_enable && (((^d) ^ rx_vec[char_len]) == parity_type_sel);
		next_fer = !rx_vec[frame_len - 4'h1] || (stop_length_sel && !rx_vec[frame_len - 4'h2]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else begin
			rx_s1 <= serial_in_pin;
			rx_s2 <= rx_s1;
		end
	end

	// midpoint sampling: eight ticks into the start bit, then every sixteen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= RX_IDLE;
			rx_shift <= 12'h000;
			rx_idx   <= 4'h0;
			rx_tick  <= 4'h0;
		end else if (!uart_on || !serial0_control_b[`ASC_CB_RE_BIT]) begin
			rx_state <= RX_IDLE;
		end else begin
			unique case (rx_state)
				RX_IDLE: if (!rx_s2) begin
					rx_state <= RX_START;
					rx_tick  <= 4'h0;
				end
				RX_START: if (tick16) begin
					rx_tick <= rx_tick + 4'h1;
					if (rx_tick == `ASC_MID_TICK) begin
						rx_tick  <= 4'h0;
						rx_idx   <= 4'h0;
						rx_shift <= 12'h000;
						rx_state <= rx_s2 ? RX_IDLE : RX_BITS;
					end
				end
				RX_BITS: if (tick16) begin
					rx_tick <= rx_tick + 4'h1;
					if (rx_sample) begin
						rx_shift <= rx_vec;
						rx_idx   <= rx_idx + 4'h1;
						if (rx_last)
							rx_state <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// buffer transfer and flags; a hardware set wins over a same-cycle read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data               <= 9'h000;
			receive_complete_flag <= 1'b0;
			framing_error_flag    <= 1'b0;
			parity_error_flag     <= 1'b0;
			overrun_error_flag    <= 1'b0;
			receive_request       <= 1'b0;
		end else begin
			receive_request <= rx_last;
			if (rx_last) begin
				rx_data               <= next_rx_data;
				receive_complete_flag <= 1'b1;
				framing_error_flag    <= next_fer;
				parity_error_flag     <= next_per;
			end else if (rd_rx) begin
				receive_complete_flag <= 1'b0;
				framing_error_flag    <= 1'b0;
				parity_error_flag     <= 1'b0;
			end
			if (rx_prelast && receive_complete_flag)
				overrun_error_flag <= 1'b1;
			else if (!uart_on || !serial0_control_b[`ASC_CB_RE_BIT])
				overrun_error_flag <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	a_load_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(shift_register_empty_flag) |-> $past(serial0_control_b[0]) && !$past(transmit_buffer_empty_flag))
		else $error("transmit started without enable or data");
	a_start_bit_low: assert property (@(posedge pclk) disable iff (!presetn)
		tx_load |=> ##1 !serial_out_pin)
		else $error("start bit not driven low");
	a_tx_req_source: assert property (@(posedge pclk) disable iff (!presetn)
		tx_load && !serial0_control_b[4] |=> transmit_request)
		else $error("transmit request missing at buffer move");
	a_tx_req_done: assert property (@(posedge pclk) disable iff (!presetn)
		tx_done && serial0_control_b[4] |=> transmit_request && shift_register_empty_flag)
		else $error("transmit request missing at completion");
	a_rx_req_flag: assert property (@(posedge pclk) disable iff (!presetn)
		receive_request |-> receive_complete_flag && $rose(receive_request))
		else $error("receive request without buffer transfer");
	a_rx_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(rx_state == RX_START) |-> $past(serial0_control_b[2]) && !$past(rx_s2))
		else $error("reception began without enable or start");
	a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
		rd_rx && !rx_last |=> !receive_complete_flag && !framing_error_flag && !parity_error_flag)
		else $error("read did not clear receive flags");
	a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
		rx_prelast && receive_complete_flag |=> overrun_error_flag)
		else $error("overrun not flagged");
	a_idle_high: assert property (@(posedge pclk) disable iff (!presetn)
		tx_state == TX_IDLE && !tx_load [*3] |-> serial_out_pin)
		else $error("idle line not high");
	a_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
		serial_out_pin && $past(serial0_control_a[5]) && $past(tx_line) |-> serial_out_oe_n)
		else $error("open drain output not released");
	// cycles since the last baud tick; any register write disarms, since the first gap after it is irregular
	logic [7:0] tick_gap;
	logic       tick_armed;
	logic       f1_plain;

	assign f1_plain = uart_on && !serial0_mode_reg[`ASC_MODE_EXT_BIT] && (serial0_control_a[1:0] == 2'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_gap   <= 8'h00;
			tick_armed <= 1'b0;
		end else begin
			tick_gap <= tick16 ? 8'h00 : tick_gap + 8'h01;
			if (!f1_plain || (access_done && pwrite))
				tick_armed <= 1'b0;
			else if (tick16)
				tick_armed <= 1'b1;
		end
	end

	a_tick_rate: assert property (@(posedge pclk) disable iff (!presetn)
		tick16 && tick_armed && f1_plain |-> tick_gap == serial0_baud_divider)
		else $error("baud tick spacing differs from divider plus one");
	a_sum_flag: assert property (@(posedge pclk) disable iff (!presetn)
		rd_rx |-> prdata[`ASC_RB_SUM_BIT]
		== (prdata[`ASC_RB_OER_BIT] || prdata[`ASC_RB_FER_BIT] || prdata[`ASC_RB_PER_BIT]))
		else $error("summary flag disagrees with error flags");
endmodule

// File: hw/asc_consts.svh
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH
// ==========================================================
// register indices (byte address is four times the index)
`define ASC_IDX_MODE      8'hA0
`define ASC_IDX_BAUD      8'hA1
`define ASC_IDX_TX_BUF    8'hA2
`define ASC_IDX_CTRL_A    8'hA4
`define ASC_IDX_CTRL_B    8'hA5
`define ASC_IDX_RX_BUF    8'hA6
// ==========================================================
// field positions
`define ASC_MODE_EXT_BIT  3
`define ASC_MODE_STOP_LENGTH_SEL_BIT 4
`define ASC_MODE_PRY_BIT  5
`define ASC_MODE_PARITY_ENABLE_BIT 6
`define ASC_CA_SHIFT_REGISTER_EMPTY_FLAG_BIT  3
`define ASC_CA_NCH_BIT    5
`define ASC_CA_ORDER_BIT  7
`define ASC_CB_TE_BIT     0
`define ASC_CB_TI_BIT     1
`define ASC_CB_RE_BIT     2
`define ASC_CB_RI_BIT     3
`define ASC_CB_IRS_BIT    4
`define ASC_RB_OER_BIT    12
`define ASC_RB_FER_BIT    13
`define ASC_RB_PER_BIT    14
`define ASC_RB_SUM_BIT    15
// ==========================================================
// mode codes and reset values
`define ASC_SMD_OFF       3'h0
`define ASC_SMD_ASYNC7    3'h4
`define ASC_SMD_ASYNC8    3'h5
`define ASC_SMD_ASYNC9    3'h6
`define ASC_RST_MODE      8'h00
`define ASC_RST_BAUD      8'h00
`define ASC_RST_CTRL_A    8'h08
`define ASC_RST_CTRL_B    8'h02
// ==========================================================
// timing counts
`define ASC_TICKS_PER_BIT 4'hF
`define ASC_MID_TICK      4'h7
`define ASC_PRE_F8        5'h07
`define ASC_PRE_F32       5'h1F
`endif

// File: hw/asc_pkg.sv
package asc_pkg;
	// receiver sequencing
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_BITS
	} asc_rx_state_e;
	// transmitter sequencing
	typedef enum logic {
		TX_IDLE,
		TX_SHIFT
	} asc_tx_state_e;
endpackage

// File: dv/asc_remote_station.sv
`timescale 1ns/1ps
// ==========================================================
// remote serial station facing the block's pins
module asc_remote_station (
	// clock
	input  wire logic clk,
	// serial lines
	input  wire logic line_in,
	output logic      line_out
);
	int          bit_clks = 16;
	int          rx_len   = 9;
	int          frames   = 0;
	logic [11:0] rx_word  = '0;
	// line idles high between frames, as a pulled-up input expects
	initial line_out = 1'b1;
	// start bit, then n raw bits lsb first; caller builds parity and stops
	task automatic send(input logic [11:0] v, input int n);
		@(posedge clk);
		line_out <= 1'b0;
		repeat (bit_clks) @(posedge clk);
		for (int k = 0; k < n; k++) begin
			line_out <= v[k];
			repeat (bit_clks) @(posedge clk);
		end
		line_out <= 1'b1;
	endtask
	// receiver samples mid-bit; stop and parity bits are kept raw for checking
	always begin
		@(negedge line_in);
		repeat (bit_clks / 2) @(posedge clk);
		for (int k = 0; k < rx_len; k++) begin
			repeat (bit_clks) @(posedge clk);
			rx_word[k] = line_in;
		end
		frames++;
	end
endmodule

// File: dv/asc_serial0_tb.sv
`timescale 1ns/1ps
module asc_serial0_tb;
	// ==========================================================
	// stimulus and observation
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd_v;
	logic [3:0]  pstrb = '0;
	logic [3:0]  strb_v = 4'hF;
	logic        pready, pslverr, serial_out_pin, serial_out_oe_n, err_v;
	logic        transmit_request, receive_request, rx_line;
	logic [1:0]  xdiv = '0;
	int          miscompares = 0, comparisons = 0, tx_req_n = 0, rx_req_n = 0;
	logic [11:0] fv [3] = '{12'h335, 12'h3B5, 12'h235};
	logic [31:0] ev [3] = '{32'h0035, 32'hC035, 32'hA035};
	// released output floats up to the pulled-up level
	wire         tx_line = serial_out_oe_n ? 1'b1 : serial_out_pin;
	wire         transfer_clock_pin = xdiv[1];
	asc_serial0 dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_in_pin(rx_line), .transfer_clock_pin(transfer_clock_pin), .serial_out_pin(serial_out_pin),
		.serial_out_oe_n(serial_out_oe_n), .transmit_request(transmit_request),
		.receive_request(receive_request));
	asc_remote_station partner_u (.clk(pclk), .line_in(tx_line), .line_out(rx_line));
	initial forever #5 pclk = ~pclk;
	// external count source rises every four clocks; request pulses counted
	always @(posedge pclk) begin
		xdiv <= xdiv + 2'h1;
		if (transmit_request === 1'b1) tx_req_n++;
		if (receive_request === 1'b1) rx_req_n++;
	end
	// ==========================================================
	// tasks
	task end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task hang(input string n);
		miscompares++;
		$display("FAIL %s timed out", n);
		end_of_test();
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	// one apb transfer; waits for pready, never assumes a latency
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= strb_v;
		@(posedge pclk);
		penable <= 1'b1;
		for (t = 0; t < 20; t++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (t == 20) hang("apb");
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// which: 0 receive pulses, 1 transmit pulses, 2 frames seen by the station
	task wait_ge(input int which, input int target);
		int t;
		for (t = 0; t < 5000; t++) begin
			if ((which == 0 ? rx_req_n : which == 1 ? tx_req_n : partner_u.frames) >= target) break;
			@(posedge pclk);
		end
		if (t == 5000) hang("event wait");
	endtask
	// ==========================================================
	// test sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h280, 0);
		chk("mode reset", rd_v, 32'h00);
		apb(0, 12'h290, 0);
		chk("ctrl_a reset", rd_v, 32'h08);
		apb(0, 12'h294, 0);
		chk("ctrl_b reset", rd_v, 32'h02);
		apb(0, 12'h28C, 0);
		chk("unmapped err", 32'(err_v), 32'h1);
		chk("idle line", 32'(serial_out_pin), 32'h1);
		$display("test reset done");
		// data waits in the buffer until transmit is enabled
		apb(1, 12'h280, 32'h05);
		apb(1, 12'h284, 32'h00);
		apb(1, 12'h288, 32'h31);
		repeat (100) @(posedge pclk);
		chk("no frame", 32'(partner_u.frames), 32'h0);
		apb(0, 12'h294, 0);
		chk("buffer full", rd_v, 32'h00);
		apb(1, 12'h294, 32'h01);
		wait_ge(2, 1);
		chk("tx lsb first", 32'(partner_u.rx_word[8:0]), 32'h131);
		chk("tx req at move", 32'(tx_req_n), 32'h1);
		// let the stop bit finish before the request source changes
		repeat (16) @(posedge pclk);
		// msb first, request only at completion
		apb(1, 12'h290, 32'h80);
		apb(1, 12'h294, 32'h11);
		apb(1, 12'h288, 32'h31);
		wait_ge(2, 2);
		chk("tx msb first", 32'(partner_u.rx_word[8:0]), 32'h18C);
		chk("no req at start", 32'(tx_req_n), 32'h1);
		wait_ge(1, 2);
		// external count source with odd parity
		apb(1, 12'h290, 32'h00);
		partner_u.bit_clks = 64;
		partner_u.rx_len = 10;
		apb(1, 12'h280, 32'h4D);
		apb(1, 12'h288, 32'h31);
		wait_ge(2, 3);
		chk("tx ext odd", 32'(partner_u.rx_word[9:0]), 32'h231);
		wait_ge(1, 3);
		apb(1, 12'h290, 32'h20);
		apb(0, 12'h290, 0);
		chk("ctrl_a od", rd_v, 32'h28);
		chk("od released", 32'(serial_out_oe_n), 32'h1);
		apb(1, 12'h290, 32'h00);
		// nine-bit character: upper byte in its own lane first, then the low byte
		partner_u.bit_clks = 16;
		apb(1, 12'h280, 32'h06);
		strb_v = 4'h2;
		apb(1, 12'h288, 32'h100);
		strb_v = 4'h1;
		apb(1, 12'h288, 32'h031);
		strb_v = 4'hF;
		wait_ge(2, 4);
		chk("tx nine bit", 32'(partner_u.rx_word[9:0]), 32'h331);
		wait_ge(1, 4);
		$display("test transmit done");
		// receive: 7 bits, even parity, two stops; good, bad parity, bad stop
		partner_u.bit_clks = 16;
		apb(1, 12'h294, 32'h04);
		apb(1, 12'h280, 32'h74);
		for (int k = 0; k < 3; k++) begin
			partner_u.send(fv[k], 10);
			wait_ge(0, k + 1);
			apb(0, 12'h294, 0);
			chk("rx complete", rd_v, 32'h0E);
			apb(0, 12'h298, 0);
			chk("rx buffer", rd_v & 32'hF07F, ev[k]);
		end
		apb(0, 12'h294, 0);
		chk("rx complete clr", rd_v, 32'h06);
		// overrun, then the recovery sequence
		partner_u.send(fv[0], 10);
		wait_ge(0, 4);
		partner_u.send(fv[0], 10);
		wait_ge(0, 5);
		apb(0, 12'h298, 0);
		chk("overrun", rd_v & 32'hF000, 32'h9000);
		apb(1, 12'h294, 32'h00);
		apb(1, 12'h280, 32'h00);
		apb(1, 12'h280, 32'h74);
		apb(1, 12'h294, 32'h05);
		partner_u.send(fv[0], 10);
		wait_ge(0, 6);
		apb(0, 12'h298, 0);
		chk("after recovery", rd_v & 32'hF07F, 32'h0035);
		$display("test receive done");
		end_of_test();
	end
endmodule
